// File: bench/adc_power_start_delay_config_bench.sv
/* Self-checking bench for the configuration bank.
   Assumes the host model drives the register port; bench drives start and done. */
`timescale 1ns/1ps
module adc_power_start_delay_config_bench
  import apsdc_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] q;} apsdc_row_t;
  logic clk = 1'b0, nrst = 1'b0, start_pin = 1'b0, conv_done = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  logic reg_wr, reg_rd, reg_rvalid, rng, pin, low, tick, conv, first, stby, pdn;
  logic [4:0] filt;
  logic [10:0] ticks;
  int errors = 0, check_count = 0;
  int dly [8] = '{0, 4, 8, 16, 32, 128, 512, 1024};
  apsdc_row_t rows [6] = '{'{8'h06, 8'hE7, 8'hA7}, '{8'h06, 8'h00, 8'h00},
    '{8'h07, 8'hA5, 8'hA5}, '{8'h07, 8'h1F, 8'h1F}, '{8'h09, 8'h55, 8'h00},
    '{8'h07, 8'h00, 8'h00}};
  always #20 clk = ~clk;
  apsdc_host host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  apsdc_top uut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .start_pin(start_pin), .conv_done(conv_done), .enlarged_range_sel(rng),
    .output_pin_function_sel(pin), .main_clock_low(low), .filter_sel(filt),
    .modulator_tick(tick), .converting(conv), .first_conv(first), .standby_active(stby),
    .power_down_ctl(pdn));
  task automatic check(string n, logic [10:0] s, logic [10:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // Window covers sync phase and one tick of phase slack
  task automatic wait_first(int p, int n);
    int c;
    c = 0;
    @(posedge clk);
    start_pin <= 1'b1;
    do begin
      @(negedge clk);
      c++;
    end while (first !== 1'b1 && c < 40000);
    check("first_delay", 11'(c >= p * n + 4 - p && c <= p * n + 6), 11'h1);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #(40 * 60000);
    errors++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    host.rd(8'h06, q);
    check("reg6_reset", 11'(q), 11'h0);
    host.rd(8'h07, q);
    check("reg7_reset", 11'(q), 11'h0);
    check("outs_reset", 11'({rng, pin, low, conv, stby, pdn, filt}), 11'h0);
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].d);
      host.rd(rows[i].a, q);
      check("readback", 11'(q), 11'(rows[i].q));
      if (rows[i].a == 8'h06) begin
        check("cfg_outs", 11'({rng, pin, low, pdn}), 11'({rows[i].d[7], rows[i].d[5],
          rows[i].d[2], rows[i].d[0]}));
      end
      if (rows[i].a == 8'h07) check("filter", 11'(filt), 11'(rows[i].d[4:0]));
    end
    for (int c = 0; c < 8; c++) begin
      host.wr(8'h07, 8'(c << 5));
      host.wr(8'h06, 8'(c % 2) << 1);
      wait_first(2, dly[c]);
      check("running", 11'(conv), 11'h1);
      @(posedge clk);
      start_pin <= 1'b0;
      repeat (8) @(negedge clk);
      check("stopped", 11'(conv), 11'h0);
      check("standby", 11'(stby), 11'(c % 2));
    end
    host.wr(8'h07, 8'h20);
    host.wr(8'h06, 8'h04);
    wait_first(16, 4);
    @(posedge clk);
    start_pin <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      host.wr(8'h06, 8'(m << 3));
      host.wr(8'h07, 8'h00);
      wait_first(2, 0);
      @(posedge clk);
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
      repeat (3) @(negedge clk);
      check("after_done", 11'(conv), 11'(m != 1));
      @(posedge clk);
      start_pin <= 1'b0;
      repeat (6) @(negedge clk);
      check("after_low", 11'(conv), 11'(m == 2));
      host.wr(8'h06, 8'h01);
      host.wr(8'h06, 8'h00);
    end
    host.wr(8'h07, 8'h4A);
    host.wr(8'h06, 8'h01);
    start_pin <= 1'b1;
    repeat (40) @(negedge clk);
    check("pdn_idle", 11'({pdn, conv}), 11'h2);
    host.rd(8'h07, q);
    check("pdn_keep", 11'(q), 11'h4A);
    host.wr(8'h06, 8'h00);
    repeat (40) @(negedge clk);
    check("pdn_exit", 11'({pdn, conv}), 11'h1);
    // Reset in mid-run, while converting with a nonzero filter code
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check("mid_reset", 11'({rng, pin, low, conv, stby, pdn, filt}), 11'h0);
    host.rd(8'h07, q);
    check("mid_reset_reg7", 11'(q), 11'h0);
    // 64 cycles hold a whole number of ticks in both speeds
    for (int s = 0; s < 2; s++) begin
      host.wr(8'h06, 8'(s << 2));
      ticks = '0;
      repeat (64) begin
        @(negedge clk);
        ticks = ticks + 11'(tick);
      end
      check("tick_rate", ticks, (s == 1) ? 11'h004 : 11'h020);
    end
    test_done();
  end
endmodule

// File: bench/apsdc_assertions.sv
/* Port checker for the configuration bank.
   Assumes binding to apsdc_top; sees its ports only. */
`timescale 1ns/1ps
module apsdc_assertions
  import apsdc_pkg::*;
(
  input wire logic              clk,                      // Core clock
  input wire logic              nrst,                     // Reset, active low
  input wire logic [ADDR_W-1:0] reg_addr,                 // Address
  input wire logic [7:0]        reg_wdata,                // Write data
  input wire logic              reg_wr,                   // Write strobe
  input wire logic              reg_rd,                   // Read strobe
  input wire logic [7:0]        reg_rdata,                // Read data
  input wire logic              reg_rvalid,               // Read valid
  input wire logic              enlarged_range_sel,       // Range select
  input wire logic              output_pin_function_sel,  // Pin function
  input wire logic              main_clock_low,           // Low speed
  input wire logic [FILTER_W-1:0] filter_sel,             // Filter code
  input wire logic              modulator_tick,           // Modulator enable
  input wire logic              converting,               // Running
  input wire logic              first_conv,               // First conversion
  input wire logic              standby_active,           // Standby
  input wire logic              power_down_ctl            // Powered down
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_read_answer:
    assert property (reg_rd |=> reg_rvalid ##1 (reg_rvalid == $past(reg_rd))) else $error("read pulse wrong");
  a_range_write:
    assert property (reg_wr && reg_addr == PWR_CFG_ADDR |=> enlarged_range_sel == $past(reg_wdata[7])) else $error("range bit");
  a_pin_write:
    assert property (reg_wr && reg_addr == PWR_CFG_ADDR |=> output_pin_function_sel == $past(reg_wdata[5])) else $error("pin bit");
  a_speed_write:
    assert property (reg_wr && reg_addr == PWR_CFG_ADDR |=> main_clock_low == $past(reg_wdata[2])) else $error("speed bit");
  a_filter_write:
    assert property (reg_wr && reg_addr == DLY_CFG_ADDR |=> filter_sel == $past(reg_wdata[4:0])) else $error("filter field");
  a_reserved_zero:
    assert property (reg_rd && reg_addr == PWR_CFG_ADDR |=> reg_rdata[6] == 1'b0) else $error("reserved bit set");
  a_pdn_quiet:
    assert property (power_down_ctl && $past(power_down_ctl) |-> !converting && !modulator_tick && !first_conv) else $error("active in power-down");
  a_tick_spacing:
    assert property (modulator_tick |=> !modulator_tick) else $error("tick too close");
  a_standby_stop:
    assert property (standby_active |-> !converting && !power_down_ctl) else $error("standby while running");
  a_first_runs:
    assert property (first_conv |-> converting ##1 !first_conv) else $error("first pulse wrong");
endmodule
bind apsdc_top apsdc_assertions chk (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .reg_rvalid, .enlarged_range_sel, .output_pin_function_sel, .main_clock_low,
  .filter_sel, .modulator_tick, .converting, .first_conv, .standby_active, .power_down_ctl);

// File: bench/apsdc_host.sv
/* Host side of the register strobe port: single write and read cycles.
   Assumes the serial decoder is abstracted away; strobes last one clk. */
`timescale 1ns/1ps
module apsdc_host (
  input  wire logic       clk,         // Core clock
  output logic      [7:0] reg_addr,    // Register address
  output logic      [7:0] reg_wdata,   // Write data
  output logic            reg_wr,      // Write strobe
  output logic            reg_rd,      // Read strobe
  input  wire logic [7:0] reg_rdata,   // Read data
  input  wire logic       reg_rvalid   // Read data valid
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Callers keep start code 11 out and pin data-only in chains
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;   // Released bus must not look valid
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge clk);
    q = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;  // No answer shows unknown
  endtask
endmodule

// File: logic/apsdc_delay.sv
/*
  First-conversion delay counter, counting modulator ticks.
  Assumes load and tick are single-cycle pulses on the core clock; abort stays high throughout power-down.
*/
`timescale 1ns/1ps
module apsdc_delay
  import apsdc_pkg::*;
(
  input  wire logic clk,   // Core clock
  input  wire logic nrst,  // Async reset, active low
  apsdc_dly_if.cnt  dly    // Control link
);

  typedef struct packed {
    logic [DLY_CNT_W-1:0] cnt;
    logic                 busy;
    logic                 done;
  } apsdc_dly_st_t;

  apsdc_dly_st_t st_reg;
  apsdc_dly_st_t st_next;

  function automatic logic [DLY_CNT_W-1:0] dly_len(input logic [2:0] c);
    case (c)
      3'h0: dly_len = DLY_C0;
      3'h1: dly_len = DLY_C1;
      3'h2: dly_len = DLY_C2;
      3'h3: dly_len = DLY_C3;
      3'h4: dly_len = DLY_C4;
      3'h5: dly_len = DLY_C5;
      3'h6: dly_len = DLY_C6;
      default: dly_len = DLY_C7;
    endcase
  endfunction

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (dly.abort) begin
      st_next.busy = 1'b0;
      st_next.cnt = '0;
    end else if (dly.load) begin
      st_next.cnt = dly_len(dly.code);
      st_next.busy = (dly_len(dly.code) != '0);
      st_next.done = (dly_len(dly.code) == '0);
    end else if (st_reg.busy && dly.tick) begin
      st_next.cnt = st_reg.cnt - 1'b1;
      if (st_reg.cnt == 11'h001) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dly.done = st_reg.done;
  assign dly.busy = st_reg.busy;

endmodule

// File: logic/apsdc_dly_if.sv
/*
  Link between the control core and the start-delay counter.
  Assumes both ends share the core clock.
*/
`timescale 1ns/1ps
interface apsdc_dly_if;
  logic        load;
  logic        abort;
  logic [2:0]  code;
  logic        tick;
  logic        done;
  logic        busy;
  modport ctl (output load, output abort, output code, output tick, input done, input busy);
  modport cnt (input load, input abort, input code, input tick, output done, output busy);
endinterface

// File: logic/apsdc_pkg.sv
/*
  Constants, register layout and state types of the power/start/delay
  configuration bank of a delta-sigma converter.
  Assumes a serial-interface decoder outside that turns host frames into
  single-cycle register read and write strobes on the core clock.
*/
// Functional notes
// - Power/start register at 6, resets to zero
// - Delay/filter register at 7, resets to zero
// - Bit 7 set enlarges input range by quarter
// - Pin function bit: data only, or data+ready
// - Start field: stop/start, one-shot, synchronized modes
// - Speed bit: 25.6 MHz high, 3.2 MHz low
// - Standby bit clear: stay powered when idle
// - Standby bit set: low power after stopping
// - Power-down keeps registers; clearing bit resumes operation
// - Delay code adds 0..1024 modulator cycles, first only
// - Delay counted in modulator cycles, half main clock
// - Filter field bits 4:0, code zero wideband 32
package apsdc_pkg;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] PWR_CFG_ADDR = 8'h06;
  localparam logic [ADDR_W-1:0] DLY_CFG_ADDR = 8'h07;
  localparam logic [7:0] PWR_CFG_RST = 8'h00;
  localparam logic [7:0] DLY_CFG_RST = 8'h00;
  localparam logic [7:0] PWR_CFG_WMASK = 8'hBF;
  localparam logic [7:0] DLY_CFG_WMASK = 8'hFF;

  // Power/start register fields
  localparam int RANGE_BIT = 7;
  localparam int PINFN_BIT = 5;
  localparam int STMODE_LSB = 3;
  localparam int SPEED_BIT = 2;
  localparam int STBY_BIT = 1;
  localparam int PDN_BIT = 0;
  // Delay/filter register fields
  localparam int DELAY_LSB = 5;
  localparam int FILTER_LSB = 0;
  localparam int FILTER_W = 5;

  localparam logic [1:0] START_LEVEL = 2'h0;
  localparam logic [1:0] START_ONESHOT = 2'h1;
  localparam logic [1:0] START_SYNC = 2'h2;
  localparam logic [4:0] FILTER_WB32 = 5'h00;

  // Main clock per speed mode; modulator runs at half of it
  localparam int MAIN_HZ_HIGH = 25_600_000;
  localparam int MAIN_HZ_LOW = 3_200_000;
  localparam int MOD_PER_MAIN = 2;
  localparam int LOW_SPEED_RATIO = MAIN_HZ_HIGH / MAIN_HZ_LOW;
  localparam logic [4:0] MOD_DIV_HIGH = 5'(MOD_PER_MAIN);
  localparam logic [4:0] MOD_DIV_LOW = 5'(MOD_PER_MAIN * LOW_SPEED_RATIO);

  localparam int DLY_CNT_W = 11;
  localparam logic [10:0] DLY_C0 = 11'h000;
  localparam logic [10:0] DLY_C1 = 11'h004;
  localparam logic [10:0] DLY_C2 = 11'h008;
  localparam logic [10:0] DLY_C3 = 11'h010;
  localparam logic [10:0] DLY_C4 = 11'h020;
  localparam logic [10:0] DLY_C5 = 11'h080;
  localparam logic [10:0] DLY_C6 = 11'h200;
  localparam logic [10:0] DLY_C7 = 11'h400;

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_RUN, ST_POWER_DOWN_CTL} apsdc_state_t;

endpackage

// File: logic/apsdc_top.sv
/*
  Power, speed, start and first-conversion delay configuration bank.
  Holds the two configuration registers, drives the converter control
  levels and sequences start, delay, run, idle/standby and power-down.
  Assumes register strobes come from a serial decoder on clk, the start
  pin is asynchronous, and conv_done is a pulse from the filter on clk.
*/
`timescale 1ns/1ps
module apsdc_top
  import apsdc_pkg::*;
(
  input  wire logic              clk,                      // Core clock, 25.6 MHz
  input  wire logic              nrst,                     // Async reset, active low
  input  wire logic [ADDR_W-1:0] reg_addr,                 // Register address
  input  wire logic [7:0]        reg_wdata,                // Write data
  input  wire logic              reg_wr,                   // Write strobe
  input  wire logic              reg_rd,                   // Read strobe
  output logic      [7:0]        reg_rdata,                // Read data
  output logic                   reg_rvalid,               // Read data valid
  input  wire logic              start_pin,                // Start pin, async
  input  wire logic              conv_done,                // End of one conversion
  output logic                   enlarged_range_sel,       // Input range +25%
  output logic                   output_pin_function_sel,  // Shared pin carries ready
  output logic                   main_clock_low,           // Low-speed main clock
  output logic [FILTER_W-1:0]    filter_sel,               // Filter type and ratio
  output logic                   modulator_tick,           // Modulator clock enable
  output logic                   converting,               // Conversions running
  output logic                   first_conv,               // First conversion begins
  output logic                   standby_active,           // Low-power standby
  output logic                   power_down_ctl            // Analog powered down
);

  typedef struct packed {
    logic [7:0]   pwr_cfg;
    logic [7:0]   dly_cfg;
    logic [7:0]   rdata;
    logic         rvalid;
    logic         start_m;
    logic         start_s;
    logic         start_d;
    logic [4:0]   div_cnt;
    logic         tick;
    apsdc_state_t state;
    logic         first;
    logic         standby;
    logic         pdown;
    logic         run;
  } apsdc_top_st_t;

  apsdc_top_st_t st_reg;
  apsdc_top_st_t st_next;

  apsdc_dly_if dly ();

  apsdc_delay u_delay (
    .clk  (clk),
    .nrst (nrst),
    .dly  (dly)
  );

  logic [1:0] start_mode;
  logic       start_rise;
  logic       start_req;
  logic       stop_req;
  logic [4:0] div_last;
  logic       go_idle;

  assign start_mode = st_reg.pwr_cfg[STMODE_LSB +: 2];
  assign start_rise = st_reg.start_s && !st_reg.start_d;
  assign div_last = (st_reg.pwr_cfg[SPEED_BIT] ? MOD_DIV_LOW : MOD_DIV_HIGH) - 5'h01;

  always_comb begin
    start_req = 1'b0;
    stop_req = 1'b0;
    case (start_mode)
      START_LEVEL: begin
        start_req = st_reg.start_s;
        stop_req = !st_reg.start_s;
      end
      START_ONESHOT: begin
        start_req = start_rise;
        stop_req = conv_done;
      end
      START_SYNC: begin
        start_req = start_rise;
        stop_req = 1'b0;
      end
      default: begin
        // Reserved code: no conversions are started
        start_req = 1'b0;
        stop_req = 1'b1;
      end
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    st_next.first = 1'b0;
    go_idle = 1'b0;
    dly.load = 1'b0;
    dly.abort = 1'b0;
    dly.code = st_reg.dly_cfg[DELAY_LSB +: 3];
    dly.tick = st_reg.tick;

    // Serial access stays alive in every state, power-down included
    if (reg_wr) begin
      if (reg_addr == PWR_CFG_ADDR) begin
        st_next.pwr_cfg = reg_wdata & PWR_CFG_WMASK;
      end else if (reg_addr == DLY_CFG_ADDR) begin
        st_next.dly_cfg = reg_wdata & DLY_CFG_WMASK;
      end
    end
    if (reg_rd) begin
      st_next.rvalid = 1'b1;
      if (reg_addr == PWR_CFG_ADDR) begin
        st_next.rdata = st_reg.pwr_cfg & PWR_CFG_WMASK;
      end else if (reg_addr == DLY_CFG_ADDR) begin
        st_next.rdata = st_reg.dly_cfg;
      end else begin
        st_next.rdata = 8'h00;
      end
    end

    // Two-stage synchroniser, edge detect compares the second stage with its delayed copy
    st_next.start_m = start_pin;
    st_next.start_s = st_reg.start_m;
    st_next.start_d = st_reg.start_s;

    // Modulator enable: half the main clock, eight times slower in low speed
    st_next.tick = 1'b0;
    if (st_reg.state == ST_POWER_DOWN_CTL) begin
      st_next.div_cnt = 5'h00;
    end else if (st_reg.div_cnt >= div_last) begin
      st_next.div_cnt = 5'h00;
      st_next.tick = 1'b1;
    end else begin
      st_next.div_cnt = st_reg.div_cnt + 5'h01;
    end

    case (st_reg.state)
      ST_IDLE: begin
        if (start_req) begin
          dly.load = 1'b1;
          st_next.state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (stop_req && start_mode != START_ONESHOT) begin
          dly.abort = 1'b1;
          go_idle = 1'b1;
        end else if (dly.done) begin
          st_next.first = 1'b1;
          st_next.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stop_req) begin
          go_idle = 1'b1;
        end else if (start_mode == START_SYNC && start_rise) begin
          // Resync restarts the sequence, so the delay applies again
          dly.load = 1'b1;
          st_next.state = ST_DELAY;
        end
      end
      ST_POWER_DOWN_CTL: begin
        if (!st_reg.pwr_cfg[PDN_BIT]) begin
          st_next.state = ST_IDLE;
        end
      end
      default: begin
        st_next.state = ST_IDLE;
      end
    endcase

    if (go_idle) begin
      st_next.state = ST_IDLE;
    end
    if (st_reg.pwr_cfg[PDN_BIT]) begin
      dly.abort = 1'b1;
      dly.load = 1'b0;
      st_next.first = 1'b0;
      st_next.state = ST_POWER_DOWN_CTL;
    end

    st_next.pdown = (st_next.state == ST_POWER_DOWN_CTL);
    // Registered copy of the run state keeps the output glitch-free
    st_next.run = (st_next.state == ST_RUN);
    // Idle stays fully powered unless auto standby is chosen
    st_next.standby = (st_next.state == ST_IDLE) && st_reg.pwr_cfg[STBY_BIT];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.pwr_cfg <= PWR_CFG_RST;
      st_reg.dly_cfg <= DLY_CFG_RST;
      st_reg.state <= ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign reg_rvalid = st_reg.rvalid;
  assign enlarged_range_sel = st_reg.pwr_cfg[RANGE_BIT];
  assign output_pin_function_sel = st_reg.pwr_cfg[PINFN_BIT];
  assign main_clock_low = st_reg.pwr_cfg[SPEED_BIT];
  assign filter_sel = st_reg.dly_cfg[FILTER_LSB +: FILTER_W];
  assign modulator_tick = st_reg.tick;
  assign converting = st_reg.run;
  assign first_conv = st_reg.first;
  assign standby_active = st_reg.standby;
  assign power_down_ctl = st_reg.pdown;

endmodule
